// ---- rtl/i2c_status_pkg.sv ----
package i2c_status_pkg;

   // Register bus geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] OFS_ENABLE_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SLAVE_ADDR  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_EN_STATUS   = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS  = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_INT_MASK    = 8'h10;

   // Field positions of enable_status.
   localparam int ST_EN_BIT   = 0;
   localparam int ST_BUSY_BIT = 1;
   localparam int ST_LOST_BIT = 2;

   // Field positions of the interrupt status and mask registers.
   localparam int IRQ_W        = 3;
   localparam int IRQ_BUSY_BIT = 0;
   localparam int IRQ_LOST_BIT = 1;
   localparam int IRQ_OFF_BIT  = 2;

   // Values after reset.
   localparam logic [6:0]       SLAVE_ADDR_RESET = 7'h55;
   localparam logic [IRQ_W-1:0] INT_MASK_RESET   = 3'h0;
   localparam logic [3:0]       BIT_CNT_RESET    = 4'h0;

   // Bit counts within one I2C byte frame.
   localparam logic [3:0] BITS_BEFORE_LAST = 4'h7;
   localparam logic [3:0] BITS_BYTE        = 4'h8;
   localparam logic [3:0] BITS_WITH_ACK    = 4'h9;

   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR,
      PH_SRX,
      PH_STX,
      PH_OTHER
   } phase_t;

   typedef enum logic [1:0] {
      EN_OFF,
      EN_ON,
      EN_DRAIN
   } en_state_t;

endpackage

// ---- rtl/bus_evt_if.sv ----
`timescale 1ns/100ps
// Sampled I2C bus events, all one-cycle pulses on REF_CLK except sda.
interface bus_evt_if;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   logic sda;

   modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
   modport snk (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// ---- rtl/pin_sampler.sv ----
`timescale 1ns/100ps
module pin_sampler (
   // Clock and control
   input  wire logic  clk,
   input  wire logic  rst,
   input  wire logic  ce,
   // Raw pins
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   // Events
   bus_evt_if.src     ev
);
   // Stage 1 and 2 synchronise; stage 3 is the history for edge detection.
   logic [1:0] scl_s1_q;
   logic [1:0] scl_s2_q;
   logic [1:0] scl_s3_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_s1_q <= 2'h3;
         scl_s2_q <= 2'h3;
         scl_s3_q <= 2'h3;
      end else if (ce) begin
         scl_s1_q <= {sda_in, scl_in};
         scl_s2_q <= scl_s1_q;
         scl_s3_q <= scl_s2_q;
      end
   end

   wire scl_now  = scl_s2_q[0];
   wire scl_old  = scl_s3_q[0];
   wire sda_now  = scl_s2_q[1];
   wire sda_old  = scl_s3_q[1];

   assign ev.scl_rise = ce & scl_now & ~scl_old;
   assign ev.scl_fall = ce & ~scl_now & scl_old;
   assign ev.start    = ce & scl_now & scl_old & sda_old & ~sda_now;
   assign ev.stop     = ce & scl_now & scl_old & ~sda_old & sda_now;
   assign ev.sda      = sda_now;
endmodule

// ---- rtl/bit_framer.sv ----
`timescale 1ns/100ps
module bit_framer
   import i2c_status_pkg::*;
(
   // Clock and control
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        ce,
   // Events
   bus_evt_if.snk           ev,
   // Frame outputs
   output logic       [7:0] byte_o,
   output logic       [3:0] bit_cnt_o,
   output logic             byte_done,
   output logic             ack_end
);
   logic [6:0] shift_q;
   logic [3:0] cnt_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         shift_q <= 7'h00;
         cnt_q   <= BIT_CNT_RESET;
      end else if (ce) begin
         if (ev.start) begin
            cnt_q <= BIT_CNT_RESET;
         end else if (ev.scl_rise && cnt_q < BITS_WITH_ACK) begin
            cnt_q   <= cnt_q + 4'h1;
            shift_q <= {shift_q[5:0], ev.sda};
         end else if (ev.scl_fall && cnt_q == BITS_WITH_ACK) begin
            cnt_q <= BIT_CNT_RESET;
         end
      end
   end

   // The full byte is valid in the cycle of byte_done, sampled bit included.
   assign byte_o    = {shift_q, ev.sda};
   assign bit_cnt_o = cnt_q;
   assign byte_done = ev.scl_rise & ~ev.start & (cnt_q == BITS_BEFORE_LAST);
   assign ack_end   = ev.scl_fall & ~ev.start & (cnt_q == BITS_WITH_ACK);
endmodule

// ---- rtl/i2c_enable_status_report.sv ----
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps
// Function
// - Disable during address byte of a slave-transmit sets the disabled-while-busy flag.
// - Disable during address or data of a slave-receive also sets that flag.
// - When that flag is set, a NACK was forced unless a STOP or START ended the transfer first, whatever the address.
// - A transfer finishing between disable request and effect sets that flag.
// - A STOP before the forced NACK after disable also sets that flag.
// - Disable while acting as master or with idle bus leaves the flag clear.
// - Status bit 0 equals the value on the enable output port.
// - Status bit 0 is 1 while enabled, 0 only when fully inactive.
// - Bit 0 readable anytime; bits 2 and 1 valid only once bit 0 reads 0.
// - While the enable control bit is 1, bits 2:1 read 0 and bit 0 reads 1; bit 0 is the enable output, so 0 in the cycle before the block turns on.
// - Data-lost flag set when disable aborts a matched slave-receive after a data byte.
// - After disable, status bit 0 may stay 1 until bus activity allows shutdown.
module i2c_enable_status_report
   import i2c_status_pkg::*;
#(
   parameter int DATA_W_P = DATA_W
) (
   // Clock and reset
   input  wire logic                                 REF_CLK,
   input  wire logic                                 SYS_RST,
   input  wire logic                                 CE,
   // Register port
   input  wire logic [i2c_status_pkg::ADDR_W-1:0]    ADDR,
   input  wire logic [DATA_W_P-1:0]                  WDATA,
   input  wire logic                                 WR,
   input  wire logic                                 RD,
   output logic      [DATA_W_P-1:0]                  RDATA,
   // I2C bus pins, sampled only
   input  wire logic                                 SCL_IN,
   input  wire logic                                 SDA_IN,
   // Controller side
   input  wire logic                                 MASTER_ACTIVE,
   output logic                                      ENABLE_OUT,
   output logic                                      NACK_FORCE,
   output logic                                      IRQ
);
   import i2c_status_pkg::*;

   if (DATA_W_P < 8) begin : g_width_check
      $error("DATA_W_P must be at least 8");
   end

   bus_evt_if ev ();

   logic [7:0] byte_w;
   logic [3:0] bit_cnt_w;
   logic       byte_done_w;
   logic       ack_end_w;

   pin_sampler u_pins (
      .clk    (REF_CLK),
      .rst    (SYS_RST),
      .ce     (CE),
      .scl_in (SCL_IN),
      .sda_in (SDA_IN),
      .ev     (ev.src)
   );

   bit_framer u_framer (
      .clk       (REF_CLK),
      .rst       (SYS_RST),
      .ce        (CE),
      .ev        (ev.snk),
      .byte_o    (byte_w),
      .bit_cnt_o (bit_cnt_w),
      .byte_done (byte_done_w),
      .ack_end   (ack_end_w)
   );

   // Registers.
   logic             ctrl_en_q;
   logic [6:0]       slave_addr_q;
   logic [IRQ_W-1:0] int_status_q;
   logic [IRQ_W-1:0] int_status_d;
   logic [IRQ_W-1:0] int_mask_q;
   logic             busy_flag_q;
   logic             busy_flag_d;
   logic             lost_flag_q;
   logic             lost_flag_d;
   logic             data_seen_q;
   logic             data_seen_d;
   phase_t           phase_q;
   phase_t           phase_d;
   en_state_t        en_q;
   en_state_t        en_d;
   logic [DATA_W_P-1:0] rdata_q;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      return a == ofs;
   endfunction

   // Bus write decode.
   wire wr_ctrl  = CE & WR & hit(ADDR, OFS_ENABLE_CTRL);
   wire wr_sar   = CE & WR & hit(ADDR, OFS_SLAVE_ADDR);
   wire wr_intst = CE & WR & hit(ADDR, OFS_INT_STATUS);
   wire wr_mask  = CE & WR & hit(ADDR, OFS_INT_MASK);

   // Bus phase tracking, independent of the enable state.
   // Tracking goes on while disabled, so a disable request always sees the transfer already in flight.
   wire addr_match = byte_w[7:1] == slave_addr_q;
   wire is_read    = byte_w[0];

   always_comb begin
      phase_d     = phase_q;
      data_seen_d = data_seen_q;
      if (ev.stop) begin
         phase_d     = PH_IDLE;
         data_seen_d = 1'b0;
      end else if (ev.start) begin
         phase_d     = PH_ADDR;
         data_seen_d = 1'b0;
      end else if (byte_done_w) begin
         unique case (phase_q)
            PH_ADDR: begin
               if (!addr_match) begin
                  phase_d = PH_OTHER;
               end else if (is_read) begin
                  phase_d = PH_STX;
               end else begin
                  phase_d = PH_SRX;
               end
            end
            PH_SRX: begin
               data_seen_d = 1'b1;
            end
            PH_IDLE, PH_STX, PH_OTHER: begin
               phase_d = phase_q;
            end
            default: begin
               phase_d = PH_IDLE;
            end
         endcase
      end
   end

   // A slave transfer counts as busy from its address byte through the end of its data.
   wire slave_busy  = (phase_q == PH_ADDR) || (phase_q == PH_SRX) || (phase_q == PH_STX);
   // The decision uses the registered control bit, so shutdown is judged one cycle after the write.
   wire disable_req = (en_q == EN_ON) && !ctrl_en_q;

   // Enable state and the two abort flags.
   always_comb begin
      en_d        = en_q;
      busy_flag_d = busy_flag_q;
      lost_flag_d = lost_flag_q;
      unique case (en_q)
         EN_OFF: begin
            // Flags clear only when a new enable starts, so they survive the whole off period.
            if (ctrl_en_q) begin
               en_d        = EN_ON;
               busy_flag_d = 1'b0;
               lost_flag_d = 1'b0;
            end
         end
         EN_ON: begin
            if (disable_req) begin
               if (MASTER_ACTIVE || !slave_busy) begin
                  en_d = EN_OFF;
               end else begin
                  en_d        = EN_DRAIN;
                  busy_flag_d = 1'b1;
                  lost_flag_d = (phase_q == PH_SRX) && data_seen_q;
               end
            end
         end
         EN_DRAIN: begin
            // The forced NACK ends the transfer; a STOP that beats it ends it too.
            if (ev.stop || ev.start || ack_end_w) begin
               en_d = EN_OFF;
            end
            if (byte_done_w && phase_q == PH_SRX) begin
               lost_flag_d = 1'b1;
            end
         end
         default: begin
            en_d = EN_OFF;
         end
      endcase
   end

   // Hardware set wins over a software clear in the same cycle.
   wire [IRQ_W-1:0] irq_set;
   assign irq_set[IRQ_BUSY_BIT] = CE & ~busy_flag_q & busy_flag_d;
   assign irq_set[IRQ_LOST_BIT] = CE & ~lost_flag_q & lost_flag_d;
   assign irq_set[IRQ_OFF_BIT]  = CE & (en_q != EN_OFF) & (en_d == EN_OFF);

   always_comb begin
      int_status_d = int_status_q;
      if (wr_intst) begin
         int_status_d = int_status_q & ~WDATA[IRQ_W-1:0];
      end
      int_status_d = int_status_d | irq_set;
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ctrl_en_q    <= 1'b0;
         slave_addr_q <= SLAVE_ADDR_RESET;
         int_mask_q   <= INT_MASK_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_en_q <= WDATA[0];
         end
         if (wr_sar) begin
            slave_addr_q <= WDATA[6:0];
         end
         if (wr_mask) begin
            int_mask_q <= WDATA[IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         phase_q      <= PH_IDLE;
         data_seen_q  <= 1'b0;
         en_q         <= EN_OFF;
         busy_flag_q  <= 1'b0;
         lost_flag_q  <= 1'b0;
         int_status_q <= '0;
      end else if (CE) begin
         phase_q      <= phase_d;
         data_seen_q  <= data_seen_d;
         en_q         <= en_d;
         busy_flag_q  <= busy_flag_d;
         lost_flag_q  <= lost_flag_d;
         int_status_q <= int_status_d;
      end
   end

   // Status view: the enable bit is the enable output itself; flags are masked while enable is set.
   // Bits 2:1 are only trustworthy once bit 0 reads 0, because the flags stop moving then.
   wire             en_live = en_q != EN_OFF;
   wire [2:0]       status_v;
   assign status_v[ST_EN_BIT]   = en_live;
   assign status_v[ST_BUSY_BIT] = busy_flag_q & ~ctrl_en_q;
   assign status_v[ST_LOST_BIT] = lost_flag_q & ~ctrl_en_q;

   wire [DATA_W_P-1:0] rd_mux =
      hit(ADDR, OFS_ENABLE_CTRL) ? DATA_W_P'(ctrl_en_q) :
      hit(ADDR, OFS_SLAVE_ADDR)  ? DATA_W_P'(slave_addr_q) :
      hit(ADDR, OFS_EN_STATUS)   ? DATA_W_P'(status_v) :
      hit(ADDR, OFS_INT_STATUS)  ? DATA_W_P'(int_status_q) :
      hit(ADDR, OFS_INT_MASK)    ? DATA_W_P'(int_mask_q) : '0;

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         rdata_q <= '0;
      end else if (CE) begin
         rdata_q <= RD ? rd_mux : '0;
      end
   end

   assign RDATA      = rdata_q;
   assign ENABLE_OUT = en_live;
   // Releasing SDA in the acknowledge bit is the NACK; the driver honours this level.
   assign NACK_FORCE = (en_q == EN_DRAIN) && (bit_cnt_w == BITS_BYTE);
   assign IRQ        = |(int_status_q & int_mask_q);

   // Checks.
   // Most checks look one cycle after the cause, since the state registers answer at the next edge.
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);

   chk_status_en_out: assert property (
      CE && RD && hit(ADDR, OFS_EN_STATUS) |=> RDATA[ST_EN_BIT] == $past(ENABLE_OUT))
      else $error("status bit 0 differs from enable output");

   chk_forced_on_read: assert property (
      CE && RD && hit(ADDR, OFS_EN_STATUS) && ctrl_en_q && en_live |=> RDATA[2:0] == 3'h1)
      else $error("status not forced while enable control is set");

   chk_master_off: assert property (
      CE && disable_req && MASTER_ACTIVE |=> !ENABLE_OUT && !busy_flag_q)
      else $error("disable as master did not shut down cleanly");

   chk_idle_off: assert property (
      CE && disable_req && phase_q == PH_IDLE |=> !ENABLE_OUT && !busy_flag_q)
      else $error("disable on idle bus did not shut down cleanly");

   chk_addr_busy: assert property (
      CE && disable_req && !MASTER_ACTIVE && phase_q == PH_ADDR |=> busy_flag_q && en_q == EN_DRAIN)
      else $error("disable in address byte did not flag busy");

   chk_srx_busy: assert property (
      CE && disable_req && !MASTER_ACTIVE && phase_q == PH_SRX |=> busy_flag_q && ENABLE_OUT)
      else $error("disable in slave receive did not flag busy");

   chk_nack_drive: assert property (
      CE && en_q == EN_DRAIN && byte_done_w |=> NACK_FORCE && busy_flag_q)
      else $error("no forced NACK during drain");

   chk_stop_end: assert property (
      CE && en_q == EN_DRAIN && ev.stop |=> !ENABLE_OUT && busy_flag_q)
      else $error("STOP during drain did not end it with flag set");

   chk_drain_holds: assert property (
      CE && en_q == EN_DRAIN && !ev.stop && !ev.start && !ack_end_w |=> ENABLE_OUT)
      else $error("enable dropped before bus activity allowed");

   chk_rx_lost: assert property (
      CE && en_q == EN_DRAIN && phase_q == PH_SRX && byte_done_w |=> lost_flag_q)
      else $error("data lost flag not set");

   chk_nack_release: assert property (
      CE && NACK_FORCE && ev.scl_rise |=> !NACK_FORCE)
      else $error("forced NACK held past the acknowledge bit");

   chk_nack_scope: assert property (
      NACK_FORCE |-> ENABLE_OUT && busy_flag_q)
      else $error("NACK forced outside a drain");

   chk_off_stable: assert property (
      CE && en_q == EN_OFF && !ctrl_en_q |=> $stable(busy_flag_q) && $stable(lost_flag_q))
      else $error("flags moved while the block is off");

   chk_status_flags: assert property (
      CE && RD && hit(ADDR, OFS_EN_STATUS) && !ctrl_en_q |=>
         RDATA[ST_BUSY_BIT] == $past(busy_flag_q) && RDATA[ST_LOST_BIT] == $past(lost_flag_q))
      else $error("status flags differ from the captured flags");

   chk_enable_clears: assert property (
      CE && en_q == EN_OFF && ctrl_en_q |=> ENABLE_OUT && !busy_flag_q && !lost_flag_q)
      else $error("enable did not start with clear flags");

   chk_other_off: assert property (
      CE && disable_req && !MASTER_ACTIVE && phase_q == PH_OTHER |=> !ENABLE_OUT && !busy_flag_q)
      else $error("disable during a foreign transfer was held back");

   chk_lost_entry: assert property (
      CE && disable_req && !MASTER_ACTIVE && phase_q == PH_SRX && data_seen_q |=> lost_flag_q)
      else $error("data lost flag missing after a received byte");

   chk_addr_no_loss: assert property (
      CE && disable_req && !MASTER_ACTIVE && phase_q == PH_ADDR |=> !lost_flag_q)
      else $error("data lost flag set before any data byte");

   chk_ack_end_off: assert property (
      CE && en_q == EN_DRAIN && ack_end_w |=> !ENABLE_OUT)
      else $error("drain did not end after the acknowledge bit");
endmodule

// ---- test/i2c_remote_master.sv ----
`timescale 1ns/100ps
// Remote bus master. The lines carry pull-ups, so a released SDA reads 1 and an unanswered
// acknowledge slot is a NACK. SCL stands high between frames.
module i2c_remote_master (
   // Bus lines after the pull-ups
   output logic scl,
   output logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // The first step leaves the clock edge, so no later pin change lands on a sampling edge.
   task automatic start_cond();
      #1 sda = 1'b0;
      #40;
      scl = 1'b0;
   endtask

   // Bits go out MSB first, 80 ns per SCL period.
   task automatic send_bits(input logic [7:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         #20 sda = b[7-i];
         #20 scl = 1'b1;
         #40 scl = 1'b0;
      end
   endtask

   task automatic ack_slot();
      send_bits(8'hff, 1);
   endtask

   task automatic stop_cond();
      #20 sda = 1'b0;
      #20 scl = 1'b1;
      #20 sda = 1'b1;
      #20;
   endtask
endmodule

// ---- test/i2c_enable_status_report_tb_top.sv ----
`timescale 1ns/100ps
module i2c_enable_status_report_tb_top;
   import i2c_status_pkg::*;

   logic              ref_clk;
   logic              sys_rst;
   logic              ce;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic              master_active;
   logic [DATA_W-1:0] rdata;
   logic              enable_out;
   logic              nack_force;
   logic              irq;
   logic              scl;
   logic              sda;
   logic [DATA_W-1:0] d;
   int                n_mismatch;
   int                check_count;

   i2c_remote_master m_u (.scl(scl), .sda(sda));

   i2c_enable_status_report #(.DATA_W_P(DATA_W)) dut_u (
      .REF_CLK(ref_clk), .SYS_RST(sys_rst), .CE(ce),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SCL_IN(scl), .SDA_IN(sda), .MASTER_ACTIVE(master_active),
      .ENABLE_OUT(enable_out), .NACK_FORCE(nack_force), .IRQ(irq)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic wait_off(input int lim);
      int n;
      n = 0;
      #1;
      while (enable_out !== 1'b0 && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk(enable_out, 1'b0);
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // The tests take about 5 us; anything far beyond that is a hang.
   initial begin
      #100000;
      n_mismatch++;
      close_out();
   end

   initial begin
      sys_rst = 1'b1;
      ce = 1'b1;
      addr = 8'h00;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
      master_active = 1'b0;
      n_mismatch = 0;
      check_count = 0;
      repeat (2) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h0);
      chk(enable_out, 1'b0);
      rd_reg(OFS_SLAVE_ADDR, d);
      chk(d, {25'h0, SLAVE_ADDR_RESET});
      rd_reg(OFS_INT_MASK, d);
      chk(d, 32'h0);
      wr_reg(OFS_EN_STATUS, 32'h7);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h0);
      rd_reg(8'h14, d);
      chk(d, 32'h0);
      // A frozen block ignores the register bus.
      @(posedge ref_clk);
      ce <= 1'b0;
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      ce <= 1'b1;
      rd_reg(OFS_ENABLE_CTRL, d);
      chk(d, 32'h0);
      // Enable, then disable on an idle bus.
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h1);
      chk(enable_out, 1'b1);
      wr_reg(OFS_ENABLE_CTRL, 32'h0);
      wait_off(4);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h0);
      // Disable while the controller is bus master.
      @(posedge ref_clk);
      master_active <= 1'b1;
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      wr_reg(OFS_ENABLE_CTRL, 32'h0);
      wait_off(4);
      @(posedge ref_clk);
      master_active <= 1'b0;
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h0);
      // Disable during the address byte of a slave-transmit.
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      fork
         begin
            m_u.start_cond();
            m_u.send_bits({SLAVE_ADDR_RESET, 1'b1}, 8);
            #20;
            chk(nack_force, 1'b1);
            m_u.ack_slot();
            m_u.stop_cond();
         end
         begin
            #200;
            wr_reg(OFS_ENABLE_CTRL, 32'h0);
            rd_reg(OFS_EN_STATUS, d);
            chk(d, 32'h3);
         end
      join
      wait_off(40);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h2);
      // Disable in the second data byte of a matched slave-receive.
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      fork
         begin
            m_u.start_cond();
            m_u.send_bits({SLAVE_ADDR_RESET, 1'b0}, 8);
            m_u.ack_slot();
            m_u.send_bits(8'ha5, 8);
            m_u.ack_slot();
            m_u.send_bits(8'h3c, 8);
            m_u.ack_slot();
            m_u.stop_cond();
         end
         begin
            #1600;
            wr_reg(OFS_ENABLE_CTRL, 32'h0);
            rd_reg(OFS_EN_STATUS, d);
            chk(d, 32'h7);
         end
      join
      wait_off(40);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h6);
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h1);
      // A STOP ends the drain before the acknowledge slot.
      fork
         begin
            m_u.start_cond();
            m_u.send_bits({SLAVE_ADDR_RESET, 1'b0}, 4);
            m_u.stop_cond();
         end
         begin
            #200;
            wr_reg(OFS_ENABLE_CTRL, 32'h0);
         end
      join
      wait_off(40);
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h2);
      // A frame for another slave does not hold the shutdown back.
      wr_reg(OFS_ENABLE_CTRL, 32'h1);
      fork
         begin
            m_u.start_cond();
            m_u.send_bits(8'h44, 8);
            m_u.ack_slot();
            m_u.stop_cond();
         end
         begin
            #760;
            wr_reg(OFS_ENABLE_CTRL, 32'h0);
            wait_off(4);
         end
      join
      rd_reg(OFS_EN_STATUS, d);
      chk(d, 32'h0);
      // Sticky events, mask and write-one-to-clear.
      rd_reg(OFS_INT_STATUS, d);
      chk(d, 32'h7);
      chk(irq, 1'b0);
      wr_reg(OFS_INT_MASK, 32'h2);
      #1;
      chk(irq, 1'b1);
      wr_reg(OFS_INT_STATUS, 32'h2);
      #1;
      chk(irq, 1'b0);
      rd_reg(OFS_INT_STATUS, d);
      chk(d, 32'h5);
      close_out();
   end
endmodule
